// ### logic/eps_lamp_stretch.sv
// eps_lamp_stretch: holds a lamp on for a visible time after an event.
// assumes ev_i is already synchronous to clk_sys_i.
`timescale 1ns/10ps
module eps_lamp_stretch import eps_pkg::*; #(
  parameter int STRETCH = EPS_STRETCH_CYC
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // event and lamp
  input  wire logic ev_i,
  output logic      lamp_o
);

  localparam int W = $clog2(STRETCH + 1);

  initial begin
    if (STRETCH < 2) begin
      $error("STRETCH must be at least 2");
    end
  end

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_lamp;

  always_comb begin
    next_cnt  = cnt;
    next_lamp = 1'b0;
    if (ev_i) begin
      next_cnt = W'(STRETCH);
    end else if (cnt != '0) begin
      next_cnt = cnt - W'(1);
    end
    next_lamp = ev_i | (cnt > W'(1));
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt    <= '0;
      lamp_o <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      lamp_o <= next_lamp;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_stretch;
    $rose(ev_i) |=> lamp_o [*2];
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("lamp not held after event");

endmodule

// ### logic/eps_port_select.sv
// eps_port_select: Ethernet attachment choice, status word and lamps.
// assumes asynchronous pins and a register master on clk_sys_i.
// How it works
// - exactly one attachment active always
// - link beat present selects twisted pair
// - no link beat switches to AUI
// - returning link beat switches back
// - status bit 6 set when AUI
// - health lamp steady, slow or rapid
// - transmit lamps per port
// - receive lamps per port
// - Ethernet receive lamp on activity of the active attachment
// - link lamp needs beat and TP selected
// - AUI lamp follows AUI selection
// - polarity lamp and automatic inversion fix
// - collision lamp on active attachment
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/10ps
module eps_port_select import eps_pkg::*; #(
  parameter int LINK_LOSS_CYC = EPS_LINK_LOSS_CYC,
  parameter int SLOW_HALF_CYC = EPS_SLOW_HALF_CYC,
  parameter int FAST_HALF_CYC = EPS_FAST_HALF_CYC,
  parameter int STRETCH_CYC   = EPS_STRETCH_CYC
) (
  // clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  // register port
  input  wire logic [EPS_ADDR_W-1:0] reg_addr_i,
  input  wire logic [EPS_DATA_W-1:0] reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [EPS_DATA_W-1:0] reg_rdata_o,
  output logic                       irq_o,
  // twisted-pair and AUI pins
  input  wire logic                  link_pulse_i,
  input  wire logic                  tp_pol_rev_i,
  input  wire logic                  tp_rxd_i,
  input  wire logic                  tp_act_i,
  input  wire logic                  aui_act_i,
  input  wire logic                  tp_col_i,
  input  wire logic                  aui_col_i,
  output logic                       tp_sel_o,
  output logic                       aui_sel_o,
  output logic                       tp_rxd_o,
  // traffic pins
  input  wire logic                  ser1_tx_i,
  input  wire logic                  ser2_tx_i,
  input  wire logic                  eth_tx_i,
  input  wire logic                  ser1_rx_i,
  input  wire logic                  ser2_rx_i,
  // lamps
  output logic                       health_lamp_o,
  output logic      [2:0]            transmit_lamp_o,
  output logic      [2:0]            receive_lamp_o,
  output logic                       link_pulse_lamp_o,
  output logic                       aui_lamp_o,
  output logic                       polarity_swap_lamp_o,
  output logic                       collision_lamp_o
);

  localparam int LW = $clog2(LINK_LOSS_CYC + 1);
  localparam int SW = $clog2(SLOW_HALF_CYC + 1);
  localparam int FW = $clog2(FAST_HALF_CYC + 1);

  initial begin
    if (FAST_HALF_CYC < 1 || SLOW_HALF_CYC <= FAST_HALF_CYC) begin
      $error("blink half periods must be distinct, slow above fast");
    end
    if (LINK_LOSS_CYC < 2 || STRETCH_CYC < 2) begin
      $error("link loss and stretch counts must be at least 2");
    end
  end

  function automatic logic pick(input eps_sel_t s, input logic tp,
                                input logic au);
    pick = (s == EPS_SEL_AUI) ? au : tp;
  endfunction

  // pin synchronisers
  logic [EPS_NPIN-1:0] pin_raw;
  logic [EPS_NPIN-1:0] pin_m;
  logic [EPS_NPIN-1:0] pin_s;
  logic                link_d;

  assign pin_raw = {ser2_rx_i, ser1_rx_i, eth_tx_i, ser2_tx_i, ser1_tx_i,
                    aui_col_i, tp_col_i, aui_act_i, tp_act_i, tp_rxd_i,
                    tp_pol_rev_i, link_pulse_i};

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pin_m  <= '0;
      pin_s  <= '0;
      link_d <= 1'b0;
    end else begin
      pin_m  <= pin_raw;
      pin_s  <= pin_m;
      link_d <= pin_s[EPS_P_LINK];
    end
  end

  // link beat watchdog and attachment choice
  logic [LW-1:0] link_cnt;
  logic [LW-1:0] next_link_cnt;
  logic          link_ok;
  eps_sel_t      sel;
  eps_sel_t      next_sel;

  assign link_ok = (link_cnt != '0);

  always_comb begin
    next_link_cnt = link_cnt;
    if (pin_s[EPS_P_LINK] && !link_d) begin
      next_link_cnt = LW'(LINK_LOSS_CYC);
    end else if (link_ok) begin
      next_link_cnt = link_cnt - LW'(1);
    end
    next_sel = sel;
    case (sel)
      EPS_SEL_AUI: begin
        if (link_ok) begin
          next_sel = EPS_SEL_TP;
        end
      end
      EPS_SEL_TP: begin
        if (!link_ok) begin
          next_sel = EPS_SEL_AUI;
        end
      end
      default: begin
        next_sel = EPS_SEL_AUI;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      link_cnt <= '0;
      sel      <= EPS_SEL_AUI;
    end else begin
      link_cnt <= next_link_cnt;
      sel      <= next_sel;
    end
  end

  assign aui_sel_o = (sel == EPS_SEL_AUI);
  assign tp_sel_o  = ~aui_sel_o;
  assign aui_lamp_o = aui_sel_o;

  // polarity fix, link lamp, blink phases, health lamp
  logic [SW-1:0] slow_cnt;
  logic [SW-1:0] next_slow_cnt;
  logic [FW-1:0] fast_cnt;
  logic [FW-1:0] next_fast_cnt;
  logic          slow_ph;
  logic          next_slow_ph;
  logic          fast_ph;
  logic          next_fast_ph;
  logic          next_rxd;
  logic          next_pol_lamp;
  logic          next_link_lamp;
  logic          next_health;
  logic [EPS_CTRL_W-1:0] ctrl;

  always_comb begin
    next_rxd      = pin_s[EPS_P_RXD] ^ pin_s[EPS_P_POL];
    next_pol_lamp = pin_s[EPS_P_POL];
    next_link_lamp = link_ok & (next_sel == EPS_SEL_TP);
    next_slow_cnt = slow_cnt - SW'(1);
    next_slow_ph  = slow_ph;
    if (slow_cnt == '0) begin
      next_slow_cnt = SW'(SLOW_HALF_CYC - 1);
      next_slow_ph  = ~slow_ph;
    end
    next_fast_cnt = fast_cnt - FW'(1);
    next_fast_ph  = fast_ph;
    if (fast_cnt == '0) begin
      next_fast_cnt = FW'(FAST_HALF_CYC - 1);
      next_fast_ph  = ~fast_ph;
    end
    if (ctrl[EPS_CTRL_FAULT]) begin
      next_health = next_slow_ph;
    end else if (ctrl[EPS_CTRL_PARAM_BAD]) begin
      next_health = next_fast_ph;
    end else begin
      next_health = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      slow_cnt             <= '0;
      fast_cnt             <= '0;
      slow_ph              <= 1'b0;
      fast_ph              <= 1'b0;
      tp_rxd_o             <= 1'b0;
      polarity_swap_lamp_o <= 1'b0;
      link_pulse_lamp_o    <= 1'b0;
      health_lamp_o        <= 1'b0;
    end else begin
      slow_cnt             <= next_slow_cnt;
      fast_cnt             <= next_fast_cnt;
      slow_ph              <= next_slow_ph;
      fast_ph              <= next_fast_ph;
      tp_rxd_o             <= next_rxd;
      polarity_swap_lamp_o <= next_pol_lamp;
      link_pulse_lamp_o    <= next_link_lamp;
      health_lamp_o        <= next_health;
    end
  end

  // stretched activity lamps
  logic [EPS_NLAMP-1:0] lamp_ev;
  logic [EPS_NLAMP-1:0] lamp_q;
  logic                 col_act;

  assign col_act = pick(sel, pin_s[EPS_P_TP_COL], pin_s[EPS_P_AU_COL]);
  assign lamp_ev = {col_act,
                    pick(sel, pin_s[EPS_P_TP_ACT], pin_s[EPS_P_AU_ACT]),
                    pin_s[EPS_P_S2_RX], pin_s[EPS_P_S1_RX],
                    pin_s[EPS_P_ET_TX], pin_s[EPS_P_S2_TX],
                    pin_s[EPS_P_S1_TX]};

  for (genvar i = 0; i < EPS_NLAMP; i++) begin : g_lamp
    eps_lamp_stretch #(
      .STRETCH (STRETCH_CYC)
    ) u_str (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .ev_i      (lamp_ev[i]),
      .lamp_o    (lamp_q[i])
    );
  end

  assign transmit_lamp_o  = lamp_q[2:0];
  assign receive_lamp_o   = lamp_q[5:3];
  assign collision_lamp_o = lamp_q[EPS_L_COL];

  // registers, events and interrupt
  logic [EPS_CTRL_W-1:0] next_ctrl;
  logic [EPS_EV_W-1:0]   evt;
  logic [EPS_EV_W-1:0]   next_evt;
  logic [EPS_EV_W-1:0]   evt_set;
  logic [EPS_EV_W-1:0]   mask;
  logic [EPS_EV_W-1:0]   next_mask;
  logic [EPS_DATA_W-1:0] status_word;
  logic [EPS_DATA_W-1:0] next_rdata;

  always_comb begin
    evt_set = '0;
    evt_set[EPS_EV_TO_AUI] = (sel == EPS_SEL_TP) && (next_sel == EPS_SEL_AUI);
    evt_set[EPS_EV_TO_TP]  = (sel == EPS_SEL_AUI) && (next_sel == EPS_SEL_TP);
    evt_set[EPS_EV_POL]    = next_pol_lamp & ~polarity_swap_lamp_o;
    evt_set[EPS_EV_COL]    = col_act;
    status_word = '0;
    status_word[EPS_ST_LINK_OK] = link_ok;
    status_word[EPS_ST_POL_REV] = polarity_swap_lamp_o;
    status_word[EPS_ST_AUI_SEL] = aui_sel_o;
    next_ctrl  = ctrl;
    next_mask  = mask;
    next_evt   = evt;
    next_rdata = '0;
    if (reg_wr_i && reg_addr_i == EPS_REG_CTRL) begin
      next_ctrl = reg_wdata_i[EPS_CTRL_W-1:0];
    end
    if (reg_wr_i && reg_addr_i == EPS_REG_MASK) begin
      next_mask = reg_wdata_i[EPS_EV_W-1:0];
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        EPS_REG_CTRL: begin
          next_rdata = {{(EPS_DATA_W-EPS_CTRL_W){1'b0}}, ctrl};
        end
        EPS_REG_STATUS: begin
          next_rdata = status_word;
        end
        EPS_REG_EVENT: begin
          next_rdata = {{(EPS_DATA_W-EPS_EV_W){1'b0}}, evt};
          next_evt   = '0;
        end
        EPS_REG_MASK: begin
          next_rdata = {{(EPS_DATA_W-EPS_EV_W){1'b0}}, mask};
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
    // a new event wins over the read clear
    next_evt = next_evt | evt_set;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl        <= EPS_CTRL_RST;
      mask        <= EPS_MASK_RST;
      evt         <= EPS_EV_RST;
      reg_rdata_o <= '0;
    end else begin
      ctrl        <= next_ctrl;
      mask        <= next_mask;
      evt         <= next_evt;
      reg_rdata_o <= next_rdata;
    end
  end

  assign irq_o = |(evt & mask);

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_one_att;
    tp_sel_o != aui_sel_o;
  endproperty
  a_one_att: assert property (p_one_att)
    else $error("both or no attachments selected");

  property p_tp_sel;
    link_ok |=> tp_sel_o;
  endproperty
  a_tp_sel: assert property (p_tp_sel)
    else $error("link beat present but TP not selected");

  property p_aui_sel;
    !link_ok |=> aui_sel_o;
  endproperty
  a_aui_sel: assert property (p_aui_sel)
    else $error("no link beat but AUI not selected");

  property p_back_tp;
    (aui_sel_o && pin_s[EPS_P_LINK] && !link_d) |-> ##2 tp_sel_o;
  endproperty
  a_back_tp: assert property (p_back_tp)
    else $error("no return to TP after link beat");

  property p_stat_bit;
    (reg_rd_i && reg_addr_i == EPS_REG_STATUS)
      |=> reg_rdata_o[EPS_ST_AUI_SEL] == $past(aui_sel_o);
  endproperty
  a_stat_bit: assert property (p_stat_bit)
    else $error("status bit 6 wrong");

  property p_health_on;
    (ctrl == '0) [*2] |=> health_lamp_o;
  endproperty
  a_health_on: assert property (p_health_on)
    else $error("health lamp not steady in good state");

  property p_link_lamp;
    ##1 link_pulse_lamp_o == $past(link_ok && next_sel == EPS_SEL_TP);
  endproperty
  a_link_lamp: assert property (p_link_lamp)
    else $error("link lamp mismatch");

  property p_pol_fix;
    ##1 tp_rxd_o == $past(pin_s[EPS_P_RXD] ^ pin_s[EPS_P_POL]);
  endproperty
  a_pol_fix: assert property (p_pol_fix)
    else $error("polarity not corrected");

  property p_col_lamp;
    col_act |=> collision_lamp_o && evt[EPS_EV_COL];
  endproperty
  a_col_lamp: assert property (p_col_lamp)
    else $error("collision not shown");

  c_to_aui: cover property (tp_sel_o ##1 aui_sel_o);
  c_to_tp:  cover property (aui_sel_o ##1 tp_sel_o);
  c_irq:    cover property ($rose(irq_o));

endmodule

// ### shared/eps_pkg.sv
// eps_pkg: constants shared by the port-select and lamp logic.
// assumes a 10 MHz module clock; all counts derive from it.
package eps_pkg;

  // clock and times
  localparam int EPS_CLK_HZ        = 10_000_000;
  localparam int EPS_CYC_PER_MS    = EPS_CLK_HZ / 1000;
  localparam int EPS_LINK_LOSS_MS  = 100;
  localparam int EPS_SLOW_HALF_MS  = 500;
  localparam int EPS_FAST_HALF_MS  = 100;
  localparam int EPS_STRETCH_MS    = 50;
  localparam int EPS_LINK_LOSS_CYC = EPS_LINK_LOSS_MS * EPS_CYC_PER_MS;
  localparam int EPS_SLOW_HALF_CYC = EPS_SLOW_HALF_MS * EPS_CYC_PER_MS;
  localparam int EPS_FAST_HALF_CYC = EPS_FAST_HALF_MS * EPS_CYC_PER_MS;
  localparam int EPS_STRETCH_CYC   = EPS_STRETCH_MS * EPS_CYC_PER_MS;

  // register port
  localparam int EPS_ADDR_W = 4;
  localparam int EPS_DATA_W = 16;
  localparam logic [EPS_ADDR_W-1:0] EPS_REG_CTRL   = 4'h0;
  localparam logic [EPS_ADDR_W-1:0] EPS_REG_STATUS = 4'h1;
  localparam logic [EPS_ADDR_W-1:0] EPS_REG_EVENT  = 4'h2;
  localparam logic [EPS_ADDR_W-1:0] EPS_REG_MASK   = 4'h3;

  // control fields
  localparam int EPS_CTRL_W         = 2;
  localparam int EPS_CTRL_FAULT     = 0;
  localparam int EPS_CTRL_PARAM_BAD = 1;
  localparam logic [EPS_CTRL_W-1:0] EPS_CTRL_RST = 2'h0;

  // module status word fields
  localparam int EPS_ST_LINK_OK = 0;
  localparam int EPS_ST_POL_REV = 1;
  localparam int EPS_ST_AUI_SEL = 6;

  // event bits
  localparam int EPS_EV_W       = 4;
  localparam int EPS_EV_TO_AUI  = 0;
  localparam int EPS_EV_TO_TP   = 1;
  localparam int EPS_EV_POL     = 2;
  localparam int EPS_EV_COL     = 3;
  localparam logic [EPS_EV_W-1:0] EPS_EV_RST   = 4'h0;
  localparam logic [EPS_EV_W-1:0] EPS_MASK_RST = 4'h0;

  // synchronised pin indices
  localparam int EPS_NPIN     = 12;
  localparam int EPS_P_LINK   = 0;
  localparam int EPS_P_POL    = 1;
  localparam int EPS_P_RXD    = 2;
  localparam int EPS_P_TP_ACT = 3;
  localparam int EPS_P_AU_ACT = 4;
  localparam int EPS_P_TP_COL = 5;
  localparam int EPS_P_AU_COL = 6;
  localparam int EPS_P_S1_TX  = 7;
  localparam int EPS_P_S2_TX  = 8;
  localparam int EPS_P_ET_TX  = 9;
  localparam int EPS_P_S1_RX  = 10;
  localparam int EPS_P_S2_RX  = 11;

  // stretched lamps: 0..2 transmit, 3..5 receive, 6 collision
  localparam int EPS_NLAMP = 7;
  localparam int EPS_L_COL = 6;

  typedef enum logic [0:0] {
    EPS_SEL_TP  = 1'b0,
    EPS_SEL_AUI = 1'b1
  } eps_sel_t;

endpackage

// ### test/eps_link_model.sv
// eps_link_model: twisted-pair link partner, sends link beat and data.
// assumes the bench steers it on clk_sys_i; line idles low between beats.
`timescale 1ns/10ps
module eps_link_model #(
  parameter int BEAT_GAP = 10
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // control from the bench
  input  wire logic beat_on_i,
  input  wire logic pol_on_i,
  input  wire logic data_i,
  // line side
  output logic      link_pulse_o,
  output logic      tp_rxd_o
);
  int cnt;

  // beats are two cycles wide so the pin synchroniser sees them
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt          <= 0;
      link_pulse_o <= 1'b0;
    end else begin
      cnt          <= (cnt == BEAT_GAP - 1) ? 0 : cnt + 1;
      link_pulse_o <= beat_on_i && (cnt < 2);
    end
  end

  // a swapped pair delivers the inverted data level
  assign tp_rxd_o = data_i ^ pol_on_i;
endmodule

// ### test/test_eps_port_select.sv
// test_eps_port_select: register tasks and port-select scenarios.
// assumes eps_pkg and the link model; counts shortened by parameters.
`timescale 1ns/10ps
module test_eps_port_select;
  import eps_pkg::*;
  localparam int STR = 4;
  logic                  clk_sys_i   = 1'b0;
  logic                  rst_i       = 1'b1;
  logic [EPS_ADDR_W-1:0] reg_addr_i  = '0;
  logic [EPS_DATA_W-1:0] reg_wdata_i = '0;
  logic                  reg_wr_i    = 1'b0;
  logic                  reg_rd_i    = 1'b0;
  logic [EPS_DATA_W-1:0] reg_rdata_o;
  logic                  irq_o;
  logic                  link_pulse_i;
  logic                  tp_rxd_i;
  logic                  tp_sel_o;
  logic                  aui_sel_o;
  logic                  tp_rxd_o;
  logic                  health_lamp_o;
  logic                  link_pulse_lamp_o;
  logic                  aui_lamp_o;
  logic                  polarity_swap_lamp_o;
  logic                  collision_lamp_o;
  logic [2:0]            transmit_lamp_o;
  logic [2:0]            receive_lamp_o;
  // tx ser1/ser2/eth, rx ser1/ser2/tp, tp collision
  logic [6:0]            ev          = '0;
  logic [6:0]            lamps;
  logic                  aui_act     = 1'b0;
  logic                  aui_col     = 1'b0;
  logic                  beat_on     = 1'b0;
  logic                  pol_on      = 1'b0;
  logic                  data        = 1'b0;
  int                    error_cnt   = 0;
  int                    num_checks  = 0;

  assign lamps = {collision_lamp_o, receive_lamp_o, transmit_lamp_o};
  always #50 clk_sys_i = ~clk_sys_i;

  eps_link_model eps_link_model_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .beat_on_i(beat_on),
    .pol_on_i(pol_on), .data_i(data), .link_pulse_o(link_pulse_i),
    .tp_rxd_o(tp_rxd_i));

  eps_port_select #(.LINK_LOSS_CYC(40), .SLOW_HALF_CYC(20),
    .FAST_HALF_CYC(5), .STRETCH_CYC(STR)) eps_port_select_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
    .link_pulse_i(link_pulse_i), .tp_pol_rev_i(pol_on),
    .tp_rxd_i(tp_rxd_i), .tp_act_i(ev[5]), .aui_act_i(aui_act),
    .tp_col_i(ev[6]), .aui_col_i(aui_col), .tp_sel_o(tp_sel_o),
    .aui_sel_o(aui_sel_o), .tp_rxd_o(tp_rxd_o), .ser1_tx_i(ev[0]),
    .ser2_tx_i(ev[1]), .eth_tx_i(ev[2]), .ser1_rx_i(ev[3]),
    .ser2_rx_i(ev[4]), .health_lamp_o(health_lamp_o),
    .transmit_lamp_o(transmit_lamp_o), .receive_lamp_o(receive_lamp_o),
    .link_pulse_lamp_o(link_pulse_lamp_o), .aui_lamp_o(aui_lamp_o),
    .polarity_swap_lamp_o(polarity_swap_lamp_o),
    .collision_lamp_o(collision_lamp_o));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask

  // bounded wait for the selection to settle
  task automatic wait_aui(input logic v, input int n);
    for (int i = 0; i < n && aui_sel_o !== v; i++) tick(1);
    chk({15'h0, aui_sel_o}, {15'h0, v});
    if (aui_sel_o !== v) end_of_test();
  endtask

  task automatic sel_chk(input logic aui);
    chk({12'h0, aui_sel_o, tp_sel_o, aui_lamp_o, link_pulse_lamp_o},
        {12'h0, aui, ~aui, aui, ~aui});
    rdchk(EPS_REG_STATUS, {9'h0, aui, 5'h0, ~aui});
  endtask

  task automatic lamp_chk(input int k);
    @(posedge clk_sys_i);
    ev[k] <= 1'b1;
    @(posedge clk_sys_i);
    ev[k] <= 1'b0;
    for (int i = 0; i < 6 && lamps[k] !== 1'b1; i++) tick(1);
    chk({9'h0, lamps}, {9'h0, 7'(1 << k)});
    tick(STR - 2);
    chk({15'h0, lamps[k]}, 16'h1);
    tick(8);
    chk({9'h0, lamps}, 16'h0);
  endtask

  // measure one whole half period after two level changes
  task automatic blink_chk(input logic [15:0] c, input int e);
    int   n;
    logic h;
    wr(EPS_REG_CTRL, c);
    repeat (2) begin
      h = health_lamp_o;
      for (int i = 0; i < 60 && health_lamp_o === h; i++) tick(1);
    end
    h = health_lamp_o;
    n = 0;
    for (int i = 0; i < 60 && health_lamp_o === h; i++) begin
      tick(1);
      n++;
    end
    chk(16'(n), 16'(e));
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    error_cnt++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end_of_test();
  end

  initial begin
    int n;
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    tick(1);
    sel_chk(1'b1);
    rdchk(4'hf, 16'h0);
    wr(EPS_REG_MASK, 16'h0002);
    rdchk(EPS_REG_MASK, 16'h0002);
    wr(EPS_REG_STATUS, 16'hffff);
    rdchk(EPS_REG_STATUS, 16'h0040);
    rdchk(EPS_REG_EVENT, 16'h0000);
    $display("test registers done");
    beat_on <= 1'b1;
    wait_aui(1'b0, 40);
    tick(2);
    sel_chk(1'b0);
    chk({15'h0, irq_o}, 16'h1);
    rdchk(EPS_REG_EVENT, 16'h0002);
    rdchk(EPS_REG_EVENT, 16'h0000);
    chk({15'h0, irq_o}, 16'h0);
    $display("test link select done");
    for (int k = 0; k < 7; k++) lamp_chk(k);
    @(posedge clk_sys_i);
    aui_col <= 1'b1;
    @(posedge clk_sys_i);
    aui_col <= 1'b0;
    tick(3);
    chk({15'h0, collision_lamp_o}, 16'h0);
    rdchk(EPS_REG_EVENT, 16'h0008);
    $display("test lamps done");
    data   <= 1'b1;
    pol_on <= 1'b1;
    tick(6);
    chk({14'h0, polarity_swap_lamp_o, tp_rxd_o}, 16'h3);
    rdchk(EPS_REG_STATUS, 16'h0003);
    chk({15'h0, irq_o}, 16'h0);
    rdchk(EPS_REG_EVENT, 16'h0004);
    pol_on <= 1'b0;
    tick(6);
    chk({14'h0, polarity_swap_lamp_o, tp_rxd_o}, 16'h1);
    $display("test polarity done");
    beat_on <= 1'b0;
    tick(25);
    chk({15'h0, aui_sel_o}, 16'h0);
    wait_aui(1'b1, 45);
    tick(2);
    sel_chk(1'b1);
    chk({15'h0, irq_o}, 16'h0);
    rdchk(EPS_REG_EVENT, 16'h0001);
    @(posedge clk_sys_i);
    aui_col <= 1'b1;
    @(posedge clk_sys_i);
    aui_col <= 1'b0;
    tick(3);
    chk({15'h0, collision_lamp_o}, 16'h1);
    rdchk(EPS_REG_EVENT, 16'h0008);
    beat_on <= 1'b1;
    wait_aui(1'b0, 40);
    tick(2);
    sel_chk(1'b0);
    $display("test switch over done");
    n = 0;
    for (int i = 0; i < 30; i++) begin
      tick(1);
      n += int'(health_lamp_o === 1'b1);
    end
    chk(16'(n), 16'd30);
    blink_chk(16'h0001, 20);
    blink_chk(16'h0002, 5);
    blink_chk(16'h0003, 20);
    $display("test health done");
    end_of_test();
  end
endmodule
